// ---- acq_consts.svh ----
// Constants of the acquisition result and configuration register slice.
// Assumes inclusion by bare name from the package and the design modules.
//
// Functional notes
// - External temperature is a read-only unsigned 16-bit result, high and low byte.
// - Current result is a read-only signed 24-bit two's complement value.
// - Current high byte reads by byte at 0x69 and by word at 0x68.
// - Voltage result is unsigned 16-bit read-only, accessed only by word operations.
// - Filter tap index selects highest coefficient used, 0 to 15, resets to 14.
// - Trigger period is 16-bit read/write, resets to zero, sets trigger counter terminal count.
// - Trigger counter counts up from zero once per low-power clock tick.
// - In low-power mode a period match starts current and temperature acquisition.
// - A zero trigger period makes low-power acquisition continuous.
// - Wake filter period is 8-bit read/write, resets to zero.
// - Hold time mask bits gate the hold time field of the same write.
// - Coefficient mask bits gate the IIR coefficient field of the same write.
// - Fast mode mask bit gates the amplifier fast mode bit of the same write.
// - Registers decode at base 0x0200 blocking and 0x0300 non-blocking.
// - Hold time code 00 disables; 01, 10, 11 hold 3, 4, 5 filter clock cycles.
// - IIR codes 000 to 100 give alpha 1/8 to 1/128; others disable the filter.
`ifndef ACQ_CONSTS_SVH
`define ACQ_CONSTS_SVH

// Bases and offsets.
`define ACQ_BASE_BLOCK     16'h0200
`define ACQ_BASE_NONBLOCK  16'h0300
`define ACQ_BASE_MASK      16'hFF00
`define ACQ_OFF_EXT_TEMP_VALUE_HI   8'h66
`define ACQ_OFF_EXT_TEMP_VALUE_LO   8'h67
`define ACQ_OFF_CURRENT_VALUE_WORD  8'h68
`define ACQ_OFF_CURRENT_VALUE_HI    8'h69
`define ACQ_OFF_CURRENT_VALUE_LO    8'h6A
`define ACQ_OFF_VOLTAGE_VALUE       8'h6C
`define ACQ_OFF_TAP        8'h6E
`define ACQ_OFF_PERIOD     8'h70
`define ACQ_OFF_WAKE       8'h72
`define ACQ_OFF_CHOP_MASK  8'h74
`define ACQ_OFF_CHOP_CTRL  8'h75

// Field positions in the chopper control byte and its mask byte.
`define ACQ_HOLD_LSB       4
`define ACQ_IIR_LSB        1
`define ACQ_FAST_BIT       0

// Reset values.
`define ACQ_TAP_RST        4'hE
`define ACQ_PERIOD_RST     16'h0000
`define ACQ_WAKE_RST       8'h00
`define ACQ_HOLD_RST       2'h0
`define ACQ_IIR_RST        3'h0
`define ACQ_FAST_RST       1'b0

// Hold time decode in filter clock cycles, and IIR decode.
`define ACQ_HOLD_CYC_01    3'h3
`define ACQ_HOLD_CYC_10    3'h4
`define ACQ_HOLD_CYC_11    3'h5
`define ACQ_IIR_LAST_CODE  3'h4
`define ACQ_IIR_BASE_SHIFT 3'h3

`endif

// ---- acq_pkg.sv ----
// Types shared by the register slice and its trigger counter.
// Assumes acq_consts.svh sits in the include path.
`include "acq_consts.svh"

package acq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic        word;
        logic [15:0] wdata;
    } acq_bus_req_t;

    typedef struct packed {
        logic [1:0] hold;
        logic [2:0] iir;
        logic       fast;
    } acq_chop_t;

    typedef struct packed {
        logic [15:0] ext_temp_value;
        logic [23:0] current_value;
        logic [15:0] voltage_value;
        logic [3:0]  tap;
        logic [15:0] period;
        logic [7:0]  wake;
        acq_chop_t   chop;
        logic [2:0]  hold_cyc;
        logic        iir_en;
        logic [2:0]  iir_shift;
        logic        contin;
        logic [15:0] rdata;
        logic        rvalid;
    } acq_regs_st_t;

    typedef struct packed {
        logic [1:0]  sync;
        logic        prev;
        logic [15:0] count;
        logic        start;
    } acq_trig_st_t;

endpackage : acq_pkg

// ---- acq_trig_counter.sv ----
// Low-power cyclic trigger counter.
// Assumes the low-power clock arrives as an asynchronous pin and is sampled here.
`include "acq_consts.svh"

module acq_trig_counter (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Low-power clock pin and mode
    input  wire logic        lpclk_pin_in,
    input  wire logic        lp_mode_in,
    input  wire logic [15:0] period_in,
    // Trigger
    output logic             start_out,
    output logic [15:0]      count_out
);

    acq_pkg::acq_trig_st_t st_q;
    acq_pkg::acq_trig_st_t st_d;
    logic                  tick;

    ////////////////////////////////////////////////////////////////////////////
    // The tick edge reads only the second sync stage, never the first.
    assign tick = st_q.sync[1] & ~st_q.prev;

    always_comb begin
        st_d       = st_q;
        st_d.sync  = {st_q.sync[0], lpclk_pin_in};
        st_d.prev  = st_q.sync[1];
        st_d.start = 1'b0;
        if (!lp_mode_in) begin
            st_d.count = 16'h0000;
        end else if (tick) begin
            if (st_q.count == period_in) begin
                st_d.start = 1'b1;
                st_d.count = 16'h0000;
            end else begin
                st_d.count = st_q.count + 16'h0001;
            end
        end
    end

    // A period lowered below the running count wraps the counter once, which is harmless.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign start_out = st_q.start;
    assign count_out = st_q.count;

endmodule : acq_trig_counter

// ---- acq_regs.sv ----
// Acquisition result and configuration register slice.
// Assumes a register port from the microcontroller and result loads from the acquisition unit,
// all on the system clock; only the low-power clock pin and SYS_RST_IN are asynchronous.
`include "acq_consts.svh"

module acq_regs (
    // Clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        SYS_RST_IN,
    // Register port
    input  wire logic [15:0] BUS_ADDR_IN,
    input  wire logic        BUS_RD_IN,
    input  wire logic        BUS_WR_IN,
    input  wire logic        BUS_WORD_IN,
    input  wire logic [15:0] BUS_WDATA_IN,
    output logic [15:0]      BUS_RDATA_OUT,
    output logic             BUS_RVALID_OUT,
    // Result loads from the acquisition unit
    input  wire logic [15:0] EXT_TEMP_VALUE_IN,
    input  wire logic        EXT_TEMP_LOAD_IN,
    input  wire logic [23:0] CURRENT_VALUE_IN,
    input  wire logic        CURRENT_LOAD_IN,
    input  wire logic [15:0] VOLTAGE_VALUE_IN,
    input  wire logic        VOLTAGE_LOAD_IN,
    // Low-power trigger
    input  wire logic        LOWPOWER_CLOCK_IN,
    input  wire logic        LOWPOWER_MODE_IN,
    output logic             ACQ_START_OUT,
    output logic             ACQ_CONTINUOUS_OUT,
    output logic [15:0]      TRIGGER_COUNT_OUT,
    // Configuration to the filter datapath
    output logic [3:0]       FILTER_TAP_INDEX_OUT,
    output logic [7:0]       WAKE_FILTER_PERIOD_OUT,
    output logic [1:0]       SWAP_HOLD_TIME_OUT,
    output logic [2:0]       HOLD_CYCLES_OUT,
    output logic [2:0]       IIR_COEFFICIENT_OUT,
    output logic             IIR_ENABLE_OUT,
    output logic [2:0]       IIR_SHIFT_OUT,
    output logic             AMP_FAST_MODE_OUT
);

    acq_pkg::acq_regs_st_t st_q;
    acq_pkg::acq_regs_st_t st_d;
    acq_pkg::acq_bus_req_t req;
    logic                  hit;
    logic [7:0]            off;
    logic [7:0]            off_even;
    logic [7:0]            wr_hi;
    logic [7:0]            wr_lo;
    logic [7:0]            mask;
    logic [7:0]            ctrl;

    ////////////////////////////////////////////////////////////////////////////
    // Byte readback. Word-only registers answer zero to byte reads.
    function automatic logic [7:0] rd_byte(input acq_pkg::acq_regs_st_t s,
                                           input logic [7:0] a,
                                           input logic w);
        logic [7:0] b;
        b = 8'h00;
        case (a)
            `ACQ_OFF_EXT_TEMP_VALUE_HI:          b = s.ext_temp_value[15:8];
            `ACQ_OFF_EXT_TEMP_VALUE_LO:          b = s.ext_temp_value[7:0];
            `ACQ_OFF_CURRENT_VALUE_HI:           b = s.current_value[23:16];
            `ACQ_OFF_CURRENT_VALUE_LO:           b = w ? s.current_value[15:8] : 8'h00;
            `ACQ_OFF_CURRENT_VALUE_LO + 8'h01:   b = w ? s.current_value[7:0] : 8'h00;
            `ACQ_OFF_VOLTAGE_VALUE:              b = w ? s.voltage_value[15:8] : 8'h00;
            `ACQ_OFF_VOLTAGE_VALUE + 8'h01:      b = w ? s.voltage_value[7:0] : 8'h00;
            `ACQ_OFF_TAP:               b = {4'h0, s.tap};
            `ACQ_OFF_PERIOD:            b = w ? s.period[15:8] : 8'h00;
            `ACQ_OFF_PERIOD + 8'h01:    b = w ? s.period[7:0] : 8'h00;
            `ACQ_OFF_WAKE:              b = s.wake;
            `ACQ_OFF_CHOP_MASK:         b = 8'h00;
            `ACQ_OFF_CHOP_CTRL:         b = {2'b00, s.chop.hold, s.chop.iir, s.chop.fast};
            default:                    b = 8'h00;
        endcase
        return b;
    endfunction : rd_byte

    // Masked update of one chopper control field.
    function automatic logic [2:0] masked(input logic [2:0] old_v,
                                          input logic [2:0] new_v,
                                          input logic [2:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction : masked

    ////////////////////////////////////////////////////////////////////////////
    // Request decode.
    assign req.addr  = BUS_ADDR_IN;
    assign req.rd    = BUS_RD_IN;
    assign req.wr    = BUS_WR_IN;
    assign req.word  = BUS_WORD_IN;
    assign req.wdata = BUS_WDATA_IN;

    // Both windows reach the same registers; the blocking distinction lies in the bus fabric.
    assign hit      = ((req.addr & `ACQ_BASE_MASK) == `ACQ_BASE_BLOCK) |
                      ((req.addr & `ACQ_BASE_MASK) == `ACQ_BASE_NONBLOCK);
    assign off      = req.addr[7:0];
    assign off_even = {off[7:1], 1'b0};
    // Word accesses are big-endian: the high data byte goes to the even offset.
    assign wr_hi    = req.word ? req.wdata[15:8] : req.wdata[7:0];
    assign wr_lo    = req.wdata[7:0];
    assign mask     = req.wdata[15:8];
    assign ctrl     = req.wdata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        st_d        = st_q;
        st_d.rvalid = 1'b0;

        if (EXT_TEMP_LOAD_IN) begin
            st_d.ext_temp_value = EXT_TEMP_VALUE_IN;
        end
        if (CURRENT_LOAD_IN) begin
            st_d.current_value = CURRENT_VALUE_IN;
        end
        if (VOLTAGE_LOAD_IN) begin
            st_d.voltage_value = VOLTAGE_VALUE_IN;
        end

        if (hit && req.wr) begin
            if (req.word) begin
                case (off_even)
                    `ACQ_OFF_TAP:    st_d.tap = wr_hi[3:0];
                    `ACQ_OFF_PERIOD: st_d.period = req.wdata;
                    `ACQ_OFF_WAKE:   st_d.wake = wr_hi;
                    `ACQ_OFF_CHOP_MASK: begin
                        // The mask byte lives only in this write and is never stored.
                        st_d.chop.hold = 2'(masked({1'b0, st_q.chop.hold},
                                                   {1'b0, ctrl[`ACQ_HOLD_LSB +: 2]},
                                                   {1'b0, mask[`ACQ_HOLD_LSB +: 2]}));
                        st_d.chop.iir  = masked(st_q.chop.iir, ctrl[`ACQ_IIR_LSB +: 3],
                                                mask[`ACQ_IIR_LSB +: 3]);
                        if (mask[`ACQ_FAST_BIT]) begin
                            st_d.chop.fast = ctrl[`ACQ_FAST_BIT];
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                // Byte writes touch only byte-wide registers; without the mask a
                // chopper byte write changes nothing.
                case (off)
                    `ACQ_OFF_TAP:  st_d.tap = wr_lo[3:0];
                    `ACQ_OFF_WAKE: st_d.wake = wr_lo;
                    default: begin
                    end
                endcase
            end
        end

        if (hit && req.rd) begin
            st_d.rvalid = 1'b1;
            if (req.word) begin
                st_d.rdata = {rd_byte(st_q, off_even, 1'b1),
                              rd_byte(st_q, {off[7:1], 1'b1}, 1'b1)};
            end else begin
                st_d.rdata = {8'h00, rd_byte(st_q, off, 1'b0)};
            end
        end else if (req.rd) begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = 16'h0000;
        end

        case (st_d.chop.hold)
            2'b01:   st_d.hold_cyc = `ACQ_HOLD_CYC_01;
            2'b10:   st_d.hold_cyc = `ACQ_HOLD_CYC_10;
            2'b11:   st_d.hold_cyc = `ACQ_HOLD_CYC_11;
            default: st_d.hold_cyc = 3'h0;
        endcase
        st_d.iir_en    = (st_d.chop.iir <= `ACQ_IIR_LAST_CODE);
        st_d.iir_shift = st_d.iir_en ? (st_d.chop.iir + `ACQ_IIR_BASE_SHIFT) : 3'h0;
        st_d.contin    = LOWPOWER_MODE_IN && (st_d.period == 16'h0000);
    end

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            st_q           <= '0;
            st_q.tap       <= `ACQ_TAP_RST;
            st_q.period    <= `ACQ_PERIOD_RST;
            st_q.wake      <= `ACQ_WAKE_RST;
            st_q.chop.hold <= `ACQ_HOLD_RST;
            st_q.chop.iir  <= `ACQ_IIR_RST;
            st_q.chop.fast <= `ACQ_FAST_RST;
            st_q.iir_en    <= 1'b1;
            st_q.iir_shift <= `ACQ_IIR_BASE_SHIFT;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger counter. Software must keep a nonzero period above one acquisition time.
    acq_trig_counter u_trig (
        .clk_in       (MCLK_IN),
        .rst_in       (SYS_RST_IN),
        .lpclk_pin_in (LOWPOWER_CLOCK_IN),
        .lp_mode_in   (LOWPOWER_MODE_IN),
        .period_in    (st_q.period),
        .start_out    (ACQ_START_OUT),
        .count_out    (TRIGGER_COUNT_OUT)
    );

    ////////////////////////////////////////////////////////////////////////////
    assign BUS_RDATA_OUT          = st_q.rdata;
    assign BUS_RVALID_OUT         = st_q.rvalid;
    assign ACQ_CONTINUOUS_OUT     = st_q.contin;
    assign FILTER_TAP_INDEX_OUT   = st_q.tap;
    assign WAKE_FILTER_PERIOD_OUT = st_q.wake;
    assign SWAP_HOLD_TIME_OUT     = st_q.chop.hold;
    assign HOLD_CYCLES_OUT        = st_q.hold_cyc;
    assign IIR_COEFFICIENT_OUT    = st_q.chop.iir;
    assign IIR_ENABLE_OUT         = st_q.iir_en;
    assign IIR_SHIFT_OUT          = st_q.iir_shift;
    assign AMP_FAST_MODE_OUT      = st_q.chop.fast;

endmodule : acq_regs

// ---- acq_regs_asserts.sv ----
// Concurrent checks on the acquisition register slice, bound into acq_regs.
// Assumes all ports share MCLK_IN and the asynchronous SYS_RST_IN.
module acq_regs_asserts (
    // Clock and reset
    input wire logic        MCLK_IN,
    input wire logic        SYS_RST_IN,
    // Register port
    input wire logic [15:0] BUS_ADDR_IN,
    input wire logic        BUS_RD_IN,
    input wire logic        BUS_WR_IN,
    input wire logic        BUS_WORD_IN,
    input wire logic [15:0] BUS_WDATA_IN,
    input wire logic        BUS_RVALID_OUT,
    // Trigger and configuration
    input wire logic        ACQ_START_OUT,
    input wire logic [15:0] TRIGGER_COUNT_OUT,
    input wire logic [1:0]  SWAP_HOLD_TIME_OUT,
    input wire logic [2:0]  HOLD_CYCLES_OUT,
    input wire logic [2:0]  IIR_COEFFICIENT_OUT,
    input wire logic        IIR_ENABLE_OUT,
    input wire logic [2:0]  IIR_SHIFT_OUT,
    input wire logic        AMP_FAST_MODE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic [5:0] mask_q;
    logic [5:0] ctrl_q;
    ////////////////////////////////////////
    // Last cycle's mask and control bytes, so each check reads as a field merge.
    always_ff @(posedge MCLK_IN) begin
        mask_q <= BUS_WDATA_IN[13:8];
        ctrl_q <= BUS_WDATA_IN[5:0];
    end
    sequence chop_wr_s;
        BUS_WR_IN && BUS_WORD_IN && BUS_ADDR_IN[15:9] == 7'h01 && BUS_ADDR_IN[7:1] == 7'h3A;
    endsequence
    ////////////////////////////////////////
    read_answer_a:
    assert property (BUS_RD_IN |=> BUS_RVALID_OUT) else $error("read not answered");
    rvalid_pulse_a:
    assert property (!BUS_RD_IN |=> !BUS_RVALID_OUT) else $error("stray read valid");
    hold_merge_a:
    assert property (chop_wr_s |=> SWAP_HOLD_TIME_OUT ==
        ($past(SWAP_HOLD_TIME_OUT) & ~mask_q[5:4] | ctrl_q[5:4] & mask_q[5:4]))
        else $error("hold field ignores its mask");
    iir_merge_a:
    assert property (chop_wr_s |=> IIR_COEFFICIENT_OUT ==
        ($past(IIR_COEFFICIENT_OUT) & ~mask_q[3:1] | ctrl_q[3:1] & mask_q[3:1]))
        else $error("coefficient field ignores its mask");
    fast_merge_a:
    assert property (chop_wr_s |=> AMP_FAST_MODE_OUT ==
        (mask_q[0] ? ctrl_q[0] : $past(AMP_FAST_MODE_OUT))) else $error("fast bit ignores mask");
    hold_decode_a:
    assert property (HOLD_CYCLES_OUT == (SWAP_HOLD_TIME_OUT == 2'h0 ? 3'h0 :
        {1'h0, SWAP_HOLD_TIME_OUT} + 3'h2)) else $error("hold cycles wrong");
    iir_decode_a:
    assert property (IIR_ENABLE_OUT == (IIR_COEFFICIENT_OUT <= 3'h4) && IIR_SHIFT_OUT ==
        (IIR_ENABLE_OUT ? IIR_COEFFICIENT_OUT + 3'h3 : 3'h0)) else $error("filter decode wrong");
    count_step_a:
    assert property ($changed(TRIGGER_COUNT_OUT) |-> TRIGGER_COUNT_OUT == 16'h0000 ||
        TRIGGER_COUNT_OUT == $past(TRIGGER_COUNT_OUT) + 16'h0001) else $error("count jumped");
    start_wrap_a:
    assert property (ACQ_START_OUT |-> TRIGGER_COUNT_OUT == 16'h0000) else $error("no wrap");
    start_pulse_a:
    assert property (ACQ_START_OUT |=> !ACQ_START_OUT [*2]) else $error("start too long");
endmodule : acq_regs_asserts

bind acq_regs acq_regs_asserts u_acq_chk (.*);

// ---- acq_host_model.sv ----
// Microcontroller model issuing byte and word accesses to the register slice.
// Assumes the slice shares clk_in; requests change 1 ns after an edge.
module acq_host_model (
    // Clock
    input wire logic        clk_in,
    // Register port
    output logic [15:0]     addr_out,
    output logic            rd_out,
    output logic            wr_out,
    output logic            word_out,
    output logic [15:0]     wdata_out,
    input wire logic [15:0] rdata_in,
    input wire logic        rvalid_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {addr_out, rd_out, wr_out, word_out, wdata_out} = '0;
    end
    ////////////////////////////////////////
    // Released lines flip, so a stale address is never taken for a fresh one.
    task automatic drop();
        rd_out = 1'h0;
        wr_out = 1'h0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
    endtask : drop
    task automatic wr(input logic [15:0] a, input logic w, input logic [15:0] d);
        @(posedge clk_in);
        #1 {addr_out, word_out, wdata_out, wr_out} = {a, w, d, 1'h1};
        @(posedge clk_in);
        #1 drop();
    endtask : wr
    // Callers read the low current word only as words, and the voltage by word and by byte.
    task automatic rd(input logic [15:0] a, input logic w, output logic [15:0] d);
        @(posedge clk_in);
        #1 {addr_out, word_out, rd_out} = {a, w, 1'h1};
        @(posedge clk_in);
        #1 drop();
        d = rvalid_in === 1'h1 ? rdata_in : 16'hxxxx;
    endtask : rd
endmodule : acq_host_model

// ---- testbench.sv ----
// Self-checking bench for acq_regs, with the host model on the register port.
// Assumes acq_pkg and the design are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [15:0] a; logic wd; logic [15:0] d;} acq_row_t;
    logic        mclk = 1'h0;
    logic        rst = 1'h1;
    logic [15:0] addr, wdata, rdata, tcount, ext_temp_value, voltage_value, got;
    logic        rd, wr, word, rvalid, et_ld, cu_ld, vo_ld, lpclk, lpmode, start, contin, fast;
    logic [23:0] current_value;
    logic [3:0]  tap;
    logic [7:0]  wake;
    logic [1:0]  hold;
    logic [2:0]  iir_coefficient;
    int          miscompares = 0, check_count = 0, cyc = 0, starts = 0, s0;
    acq_row_t    rows [26] = '{
        '{1'h0, 16'h026E, 1'h0, 16'h000E},
        '{1'h0, 16'h0270, 1'h1, 16'h0000},
        '{1'h0, 16'h0272, 1'h0, 16'h0000},
        '{1'h0, 16'h0266, 1'h1, 16'hBEEF},
        '{1'h0, 16'h0367, 1'h0, 16'h00EF},
        '{1'h0, 16'h0368, 1'h1, 16'h00F2},
        '{1'h0, 16'h0269, 1'h0, 16'h00F2},
        '{1'h0, 16'h026A, 1'h1, 16'h3456},
        '{1'h0, 16'h036C, 1'h1, 16'h8001},
        '{1'h0, 16'h026C, 1'h0, 16'h0000},
        '{1'h1, 16'h026E, 1'h0, 16'h000F},
        '{1'h0, 16'h036E, 1'h0, 16'h000F},
        '{1'h1, 16'h0370, 1'h1, 16'hFFFF},
        '{1'h0, 16'h0270, 1'h1, 16'hFFFF},
        '{1'h1, 16'h0372, 1'h0, 16'h00A5},
        '{1'h0, 16'h0272, 1'h0, 16'h00A5},
        '{1'h1, 16'h0274, 1'h1, 16'h3F15},
        '{1'h0, 16'h0275, 1'h0, 16'h0015},
        '{1'h1, 16'h0374, 1'h1, 16'h012A},
        '{1'h0, 16'h0275, 1'h0, 16'h0014},
        '{1'h1, 16'h0274, 1'h1, 16'h3E2A},
        '{1'h0, 16'h0274, 1'h1, 16'h002A},
        '{1'h1, 16'h0275, 1'h0, 16'h0000},
        '{1'h1, 16'h0374, 1'h1, 16'h3034},
        '{1'h0, 16'h0275, 1'h0, 16'h003A},
        '{1'h0, 16'h0170, 1'h1, 16'h0000}};
    acq_regs dut (
        .MCLK_IN(mclk), .SYS_RST_IN(rst),
        .BUS_ADDR_IN(addr), .BUS_RD_IN(rd), .BUS_WR_IN(wr), .BUS_WORD_IN(word),
        .BUS_WDATA_IN(wdata), .BUS_RDATA_OUT(rdata), .BUS_RVALID_OUT(rvalid),
        .EXT_TEMP_VALUE_IN(ext_temp_value), .EXT_TEMP_LOAD_IN(et_ld),
        .CURRENT_VALUE_IN(current_value), .CURRENT_LOAD_IN(cu_ld),
        .VOLTAGE_VALUE_IN(voltage_value), .VOLTAGE_LOAD_IN(vo_ld),
        .LOWPOWER_CLOCK_IN(lpclk), .LOWPOWER_MODE_IN(lpmode), .ACQ_START_OUT(start),
        .ACQ_CONTINUOUS_OUT(contin), .TRIGGER_COUNT_OUT(tcount),
        .FILTER_TAP_INDEX_OUT(tap), .WAKE_FILTER_PERIOD_OUT(wake),
        .SWAP_HOLD_TIME_OUT(hold), .HOLD_CYCLES_OUT(), .IIR_COEFFICIENT_OUT(iir_coefficient),
        .IIR_ENABLE_OUT(), .IIR_SHIFT_OUT(), .AMP_FAST_MODE_OUT(fast));
    acq_host_model mdl (
        .clk_in(mclk), .addr_out(addr), .rd_out(rd), .wr_out(wr), .word_out(word),
        .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // Ticks are eight system cycles long so the synchroniser never merges two.
    task automatic tick(input int n);
        repeat (n) begin
            lpclk = 1'h1;
            repeat (4) @(posedge mclk);
            #1 lpclk = 1'h0;
            repeat (4) @(posedge mclk);
            #1;
        end
    endtask : tick
    ////////////////////////////////////////
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (start === 1'h1) starts++;
        if (cyc == 5000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        {et_ld, cu_ld, vo_ld, lpclk, lpmode} = '0;
        {ext_temp_value, current_value, voltage_value} = {16'hBEEF, 24'hF2_3456, 16'h8001};
        repeat (4) @(posedge mclk);
        #1 rst = 1'h0;
        {et_ld, cu_ld, vo_ld} = 3'h7;
        @(posedge mclk);
        #1 {et_ld, cu_ld, vo_ld} = 3'h0;
        foreach (rows[i]) begin
            if (rows[i].w) mdl.wr(rows[i].a, rows[i].wd, rows[i].d);
            else begin
                mdl.rd(rows[i].a, rows[i].wd, got);
                chk(got, rows[i].d);
            end
        end
        $display("register rows done");
        mdl.wr(16'h0270, 1'h1, 16'h0003);
        lpmode = 1'h1;
        s0 = starts;
        tick(18);
        chk(16'(starts - s0), 16'h0004);
        chk(tcount, 16'h0002);
        lpmode = 1'h0;
        repeat (4) @(posedge mclk);
        #1 chk(tcount, 16'h0000);
        mdl.wr(16'h0270, 1'h1, 16'h0000);
        lpmode = 1'h1;
        s0 = starts;
        tick(5);
        chk(16'(starts - s0), 16'h0005);
        chk({15'h0000, contin}, 16'h0001);
        $display("trigger test done");
        rst = 1'h1;
        @(posedge mclk);
        #1 rst = 1'h0;
        chk({15'h0000, contin}, 16'h0000);
        chk({12'h000, tap}, 16'h000E);
        chk({8'h00, wake}, 16'h0000);
        chk({10'h000, hold, iir_coefficient, fast}, 16'h0000);
        mdl.rd(16'h0270, 1'h1, got);
        chk(got, 16'h0000);
        chk({15'h0000, contin}, 16'h0001);
        $display("reset test done");
        final_report();
    end
endmodule : testbench
